// ---- rtl/frpc_pkg.sv ----
package frpc_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [4:0] OFS_CTL_FIRST  = 5'h00;
	localparam logic [4:0] OFS_CTL_SECOND = 5'h04;
	localparam logic [4:0] OFS_PROTECT    = 5'h08;
	localparam logic [4:0] OFS_PMODE      = 5'h0C;
	localparam logic [4:0] OFS_STATUS     = 5'h10;
	localparam logic [4:0] OFS_COMMAND    = 5'h14;
	localparam logic [4:0] OFS_EXEC_BLOCK = 5'h18;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int B_READY     = 0;
	localparam int B_RW_EN     = 1;
	localparam int B_LOCK_DIS  = 2;
	localparam int B_AREA_SEL  = 5;
	localparam int B_PROG_ERR  = 6;
	localparam int B_ERASE_ERR = 7;
	localparam int B_EW_SEL    = 1;
	localparam int B_REJECT    = 7;
	localparam int B_BLOCK_A   = 0;
	localparam int B_EXT_AREA  = 3;
	localparam int B_SR_READY  = 7;
	localparam int B_SR_ERASE  = 5;
	localparam int B_SR_PROG   = 4;
	// ----------------------------------------
	// reset values and fixed values
	// ----------------------------------------
	localparam logic [7:0] PROTECT_RST   = 8'hFF;
	localparam logic [7:0] PROTECT_ERASED = 8'hFF;
	localparam logic [1:0] PROTECT_OFF   = 2'h3;
	localparam logic [7:0] PMODE_RST     = 8'h00;
	localparam logic [4:0] EXEC_BLK_RST  = 5'h00;
	localparam logic [31:0] VECTOR_ERASED = 32'hFFFF_FFFF;
	localparam int ID_BYTES = 7;
	// ----------------------------------------
	// software command codes
	// ----------------------------------------
	localparam logic [2:0] CMD_READ_ARRAY  = 3'h0;
	localparam logic [2:0] CMD_READ_STATUS = 3'h1;
	localparam logic [2:0] CMD_PROGRAM     = 3'h2;
	localparam logic [2:0] CMD_BLOCK_ERASE = 3'h3;
	localparam logic [2:0] CMD_ERASE_ALL   = 3'h4;
	localparam logic [2:0] CMD_LOCK_PROG   = 3'h5;
	localparam logic [2:0] CMD_READ_LOCK   = 3'h6;
	typedef enum logic {ST_IDLE, ST_BUSY} frpc_state_type;
endpackage

// ---- rtl/frpc_id_check.sv ----
module frpc_id_check (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        id_restart,
	input  wire logic        id_valid,
	input  wire logic [7:0]  id_byte,
	input  wire logic [55:0] stored_id,
	input  wire logic [31:0] reset_vector,
	output logic             accept_q
);
	logic [2:0] cnt_q;
	logic       miss_q;
	logic [7:0] ref_byte;

	// first byte sent is compared with the lowest stored byte
	assign ref_byte = stored_id[cnt_q*8 +: 8];

	// ----------------------------------------
	// byte counter and mismatch tracking
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst || id_restart) begin
			cnt_q  <= 3'h0;
			miss_q <= 1'b0;
		end else if (id_valid && cnt_q != 3'(frpc_pkg::ID_BYTES)) begin
			cnt_q <= cnt_q + 3'h1;
			if (id_byte != ref_byte)
				miss_q <= 1'b1;
		end
	end

	// commands pass only after a full match or with an erased vector
	always_ff @(posedge clk_sys) begin
		if (rst)
			accept_q <= 1'b0;
		else
			accept_q <= (reset_vector == frpc_pkg::VECTOR_ERASED) ||
				(cnt_q == 3'(frpc_pkg::ID_BYTES) && !miss_q);
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_id_mismatch_refuse: assert property (miss_q && reset_vector != frpc_pkg::VECTOR_ERASED && !id_restart |=> !accept_q)
		else $error("serial commands accepted after id mismatch");
	a_vector_skip: assert property (reset_vector == frpc_pkg::VECTOR_ERASED |=> accept_q)
		else $error("erased reset vector did not skip id check");
endmodule

// ---- rtl/frpc_top.sv ----
module frpc_top #(
	parameter int         USER_BLOCKS   = 16,
	parameter logic [4:0] PROTECT_BLOCK = 5'h00
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        boot_select_low_pin,
	input  wire logic        boot_select_high_pin,
	input  wire logic        processor_mode_pin,
	input  wire logic        par_mode_pin,
	input  wire logic        ser_mode_pin,
	input  wire logic        ser_id_restart,
	input  wire logic        ser_id_valid,
	input  wire logic [7:0]  ser_id_byte,
	input  wire logic [55:0] stored_id,
	input  wire logic [31:0] reset_vector,
	input  wire logic        ctl_block_unlocked,
	input  wire logic        core_done,
	input  wire logic        core_fail,
	output logic             core_start,
	output logic      [2:0]  core_op,
	output logic      [4:0]  core_block,
	output logic             boot_mode,
	output logic             boot_rom_sel,
	output logic             par_access_en,
	output logic             boot_rewrite_en,
	output logic             ser_cmd_accept,
	output logic             cpu_hold,
	output logic             io_freeze,
	output logic             block_a_en,
	output logic             ext_area_en,
	output logic             read_status_mode
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [4:0]  pin_m_q;
	logic [4:0]  pin_s_q;
	logic        strap_done_q;
	logic        boot_mode_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic        rw_en_q;
	logic        en_arm_q;
	logic        ew_sel_q;
	logic        ew_arm_q;
	logic        lock_dis_q;
	logic        area_sel_q;
	logic        prog_err_q;
	logic        erase_err_q;
	logic        reject_q;
	logic [7:0]  protect_q;
	logic [7:0]  pmode_q;
	logic [4:0]  exec_blk_q;
	logic        rs_mode_q;
	logic        start_q;
	logic [2:0]  op_q;
	logic [4:0]  blk_q;
	logic        boot_sel_q;
	logic        par_acc_q;
	logic        boot_wr_q;
	logic        hold_q;
	logic        blk_a_q;
	logic        ext_q;
	frpc_pkg::frpc_state_type st_q;
	logic        ser_ok;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic       wr_fire;
	logic       rd_take;
	logic [7:0] wb;
	logic       rdy;
	logic       prot_act;
	logic       busy_ew1;
	logic       op_end;
	logic       cmd_fire;
	logic [2:0] c_op;
	logic [4:0] c_blk;
	logic       long_cmd;
	logic       blk_cmd;
	logic       cmd_ok;
	logic       protect_hit;
	logic       par_s;

	assign wb       = avs_writedata[7:0];
	assign wr_fire  = avs_write && !wait_q && avs_byteenable[0];
	assign rd_take  = (avs_read || avs_write) && wait_q && !hold_q;
	assign rdy      = (st_q == frpc_pkg::ST_IDLE);
	assign prot_act = (protect_q[7:6] != frpc_pkg::PROTECT_OFF);
	assign busy_ew1 = (st_q == frpc_pkg::ST_BUSY) && ew_sel_q;
	assign op_end   = (st_q == frpc_pkg::ST_BUSY) && core_done;
	assign par_s    = pin_s_q[3];
	assign cmd_fire = wr_fire && avs_address == frpc_pkg::OFS_COMMAND;
	assign c_op     = wb[2:0];
	assign c_blk    = wb[7:3];
	assign blk_cmd  = (c_op == frpc_pkg::CMD_PROGRAM) || (c_op == frpc_pkg::CMD_BLOCK_ERASE);
	assign long_cmd = blk_cmd || c_op == frpc_pkg::CMD_ERASE_ALL ||
		c_op == frpc_pkg::CMD_LOCK_PROG || c_op == frpc_pkg::CMD_READ_LOCK;
	assign protect_hit = (op_q == frpc_pkg::CMD_ERASE_ALL) ||
		(op_q == frpc_pkg::CMD_BLOCK_ERASE && blk_q == PROTECT_BLOCK);

	// command acceptance checks
	always_comb begin
		cmd_ok = rw_en_q && rdy;
		if (c_op > frpc_pkg::CMD_READ_LOCK)
			cmd_ok = 1'b0;
		if (boot_mode_q && !area_sel_q)
			cmd_ok = 1'b0;
		if (blk_cmd && 32'(c_blk) >= USER_BLOCKS)
			cmd_ok = 1'b0;
		if (ew_sel_q && blk_cmd && c_blk == exec_blk_q)
			cmd_ok = 1'b0;
		if (ew_sel_q && c_op == frpc_pkg::CMD_ERASE_ALL && (ctl_block_unlocked || lock_dis_q))
			cmd_ok = 1'b0;
		if (ew_sel_q && c_op == frpc_pkg::CMD_READ_STATUS)
			cmd_ok = 1'b0;
	end

	// ----------------------------------------
	// pin synchronisers and strap capture
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		pin_m_q <= {ser_mode_pin, par_mode_pin, processor_mode_pin,
			boot_select_high_pin, boot_select_low_pin};
		pin_s_q <= pin_m_q;
	end

	// boot straps are caught at the first edge after reset release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strap_done_q <= 1'b0;
			boot_mode_q  <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			boot_mode_q  <= !pin_s_q[0] && pin_s_q[1] && pin_s_q[2];
		end
	end

	// ----------------------------------------
	// avalon slave handshake
	// ----------------------------------------
	// one wait cycle per access; a held cpu sees waitrequest stay high
	always_ff @(posedge clk_sys) begin
		if (rst)
			wait_q <= 1'b1;
		else if (!wait_q)
			wait_q <= 1'b1;
		else if (rd_take)
			wait_q <= 1'b0;
	end

	// read data registered as waitrequest drops
	always_ff @(posedge clk_sys) begin
		if (rst)
			rdata_q <= 32'h0000_0000;
		else if (rd_take) begin
			rdata_q <= 32'h0000_0000;
			unique case (avs_address)
				frpc_pkg::OFS_CTL_FIRST: begin
					rdata_q[frpc_pkg::B_READY]     <= rdy;
					rdata_q[frpc_pkg::B_RW_EN]     <= rw_en_q;
					rdata_q[frpc_pkg::B_LOCK_DIS]  <= lock_dis_q;
					rdata_q[frpc_pkg::B_AREA_SEL]  <= area_sel_q;
					rdata_q[frpc_pkg::B_PROG_ERR]  <= prog_err_q;
					rdata_q[frpc_pkg::B_ERASE_ERR] <= erase_err_q;
				end
				frpc_pkg::OFS_CTL_SECOND: begin
					rdata_q[frpc_pkg::B_EW_SEL] <= ew_sel_q;
					rdata_q[frpc_pkg::B_REJECT] <= reject_q;
				end
				frpc_pkg::OFS_PROTECT:    rdata_q[7:0] <= protect_q;
				frpc_pkg::OFS_PMODE:      rdata_q[7:0] <= pmode_q;
				frpc_pkg::OFS_STATUS: begin
					// status flags are hidden in erase-write-one mode
					rdata_q[frpc_pkg::B_SR_READY] <= rdy && !ew_sel_q;
					rdata_q[frpc_pkg::B_SR_ERASE] <= erase_err_q && !ew_sel_q;
					rdata_q[frpc_pkg::B_SR_PROG]  <= prog_err_q && !ew_sel_q;
				end
				frpc_pkg::OFS_EXEC_BLOCK: rdata_q[4:0] <= exec_blk_q;
				default:                  rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// control bits; rewrite enable and mode select need 0-then-1 arming
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rw_en_q    <= 1'b0;
			en_arm_q   <= 1'b0;
			lock_dis_q <= 1'b0;
			area_sel_q <= 1'b0;
		end else if (wr_fire && avs_address == frpc_pkg::OFS_CTL_FIRST) begin
			en_arm_q   <= !wb[frpc_pkg::B_RW_EN];
			lock_dis_q <= wb[frpc_pkg::B_LOCK_DIS];
			area_sel_q <= wb[frpc_pkg::B_AREA_SEL];
			if (!wb[frpc_pkg::B_RW_EN])
				rw_en_q <= 1'b0;
			else if (en_arm_q)
				rw_en_q <= 1'b1;
		end
	end

	// mode select only rises while rewrite is enabled
	always_ff @(posedge clk_sys) begin
		if (rst || !rw_en_q) begin
			ew_sel_q <= 1'b0;
			ew_arm_q <= 1'b0;
		end else if (wr_fire && avs_address == frpc_pkg::OFS_CTL_SECOND) begin
			ew_arm_q <= !wb[frpc_pkg::B_EW_SEL];
			if (!wb[frpc_pkg::B_EW_SEL])
				ew_sel_q <= 1'b0;
			else if (ew_arm_q)
				ew_sel_q <= 1'b1;
		end
	end

	// processor mode bits and control program block
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pmode_q    <= frpc_pkg::PMODE_RST;
			exec_blk_q <= frpc_pkg::EXEC_BLK_RST;
		end else if (wr_fire && avs_address == frpc_pkg::OFS_PMODE)
			pmode_q <= wb;
		else if (wr_fire && avs_address == frpc_pkg::OFS_EXEC_BLOCK)
			exec_blk_q <= wb[4:0];
	end

	// protect byte; a successful erase of its block reads as erased
	always_ff @(posedge clk_sys) begin
		if (rst)
			protect_q <= frpc_pkg::PROTECT_RST;
		else if (op_end && !core_fail && protect_hit)
			protect_q <= frpc_pkg::PROTECT_ERASED;
		else if (wr_fire && avs_address == frpc_pkg::OFS_PROTECT)
			protect_q <= wb;
	end

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q    <= frpc_pkg::ST_IDLE;
			start_q <= 1'b0;
			op_q    <= frpc_pkg::CMD_READ_ARRAY;
			blk_q   <= 5'h00;
		end else begin
			start_q <= 1'b0;
			unique case (st_q)
				frpc_pkg::ST_IDLE:
					if (cmd_fire && cmd_ok && long_cmd) begin
						st_q    <= frpc_pkg::ST_BUSY;
						start_q <= 1'b1;
						op_q    <= c_op;
						blk_q   <= c_blk;
					end
				frpc_pkg::ST_BUSY:
					if (core_done)
						st_q <= frpc_pkg::ST_IDLE;
			endcase
		end
	end

	// read mode after commands and after completion
	always_ff @(posedge clk_sys) begin
		if (rst || !rw_en_q)
			rs_mode_q <= 1'b0;
		else if (op_end)
			rs_mode_q <= !ew_sel_q;
		else if (cmd_fire && cmd_ok && c_op == frpc_pkg::CMD_READ_STATUS)
			rs_mode_q <= 1'b1;
		else if (cmd_fire && cmd_ok && c_op == frpc_pkg::CMD_READ_ARRAY)
			rs_mode_q <= 1'b0;
	end

	// error flags are set or cleared from core_fail at the end of an operation of their kind
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prog_err_q  <= 1'b0;
			erase_err_q <= 1'b0;
		end else if (op_end) begin
			if (op_q == frpc_pkg::CMD_PROGRAM)
				prog_err_q <= core_fail;
			if (op_q == frpc_pkg::CMD_BLOCK_ERASE || op_q == frpc_pkg::CMD_ERASE_ALL)
				erase_err_q <= core_fail;
		end
	end

	// refused command flag, cleared by the next taken one
	always_ff @(posedge clk_sys) begin
		if (rst)
			reject_q <= 1'b0;
		else if (cmd_fire)
			reject_q <= !cmd_ok;
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			boot_sel_q <= 1'b0;
			par_acc_q  <= 1'b0;
			boot_wr_q  <= 1'b0;
			hold_q     <= 1'b0;
			blk_a_q    <= 1'b0;
			ext_q      <= 1'b0;
		end else begin
			boot_sel_q <= boot_mode_q && !area_sel_q;
			par_acc_q  <= par_s && !prot_act;
			boot_wr_q  <= par_s && !prot_act && !rw_en_q;
			hold_q     <= busy_ew1;
			blk_a_q    <= pmode_q[frpc_pkg::B_BLOCK_A] || rw_en_q;
			ext_q      <= pmode_q[frpc_pkg::B_EXT_AREA] || rw_en_q;
		end
	end

	frpc_id_check u_id (
		.clk_sys      (clk_sys),
		.rst          (rst || !pin_s_q[4]),
		.id_restart   (ser_id_restart),
		.id_valid     (ser_id_valid),
		.id_byte      (ser_id_byte),
		.stored_id    (stored_id),
		.reset_vector (reset_vector),
		.accept_q     (ser_ok)
	);

	assign avs_readdata     = rdata_q;
	assign avs_waitrequest  = wait_q;
	assign core_start       = start_q;
	assign core_op          = op_q;
	assign core_block       = blk_q;
	assign boot_mode        = boot_mode_q;
	assign boot_rom_sel     = boot_sel_q;
	assign par_access_en    = par_acc_q;
	assign boot_rewrite_en  = boot_wr_q;
	assign ser_cmd_accept   = ser_ok;
	assign cpu_hold         = hold_q;
	assign io_freeze        = hold_q;
	assign block_a_en       = blk_a_q;
	assign ext_area_en      = ext_q;
	assign read_status_mode = rs_mode_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_op_end;
		st_q == frpc_pkg::ST_BUSY ##0 core_done;
	endsequence
	sequence s_self_cmd;
		cmd_fire && ew_sel_q && blk_cmd && c_blk == exec_blk_q;
	endsequence

	a_wait_one_cycle: assert property ((avs_read || avs_write) && wait_q && !hold_q |=> !wait_q ##1 wait_q)
		else $error("waitrequest did not pulse low for one cycle");
	a_hold_stalls_bus: assert property (hold_q && (avs_read || avs_write) && wait_q |=> wait_q)
		else $error("bus answered while cpu held");
	a_hold_ew1: assert property (busy_ew1 |=> hold_q && io_freeze)
		else $error("cpu not held during mode one operation");
	a_protect_par: assert property (prot_act && !(op_end && protect_hit) |=> !par_acc_q)
		else $error("parallel access allowed under protection");
	a_erase_clears: assert property (s_op_end ##0 !core_fail && protect_hit |=> protect_q == 8'hFF)
		else $error("protect byte not erased");
	a_self_refuse: assert property (s_self_cmd |=> !start_q && st_q == frpc_pkg::ST_IDLE)
		else $error("own block command started in mode one");
	a_erase_all_lock: assert property (cmd_fire && ew_sel_q && c_op == frpc_pkg::CMD_ERASE_ALL && (ctl_block_unlocked || lock_dis_q) |=> !start_q)
		else $error("erase-all started with block unlocked");
	a_mode_after_op: assert property (s_op_end ##0 ew_sel_q && rw_en_q |=> !rs_mode_q)
		else $error("mode one did not return to array read");
	a_ready_busy: assert property (start_q |-> !rdy ##1 !rdy)
		else $error("ready flag high during operation");
	a_enable_seq: assert property ($rose(rw_en_q) |-> $past(en_arm_q))
		else $error("rewrite enabled without prior zero write");
	a_force_pm: assert property (rw_en_q |=> blk_a_q && ext_q)
		else $error("mode bits not forced in rewrite mode");
	a_boot_map: assert property (boot_mode_q && !area_sel_q |=> boot_sel_q)
		else $error("boot area not selected");
endmodule

// ---- verification/frpc_core_model.sv ----
module frpc_core_model #(
	parameter int LAT = 8
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic core_start,
	input  wire logic fail_next,
	output logic      core_done,
	output logic      core_fail
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_q;
	// flash array: each started op runs lat cycles, then one done pulse
	always_ff @(posedge clk_sys) begin
		core_done <= 1'b0;
		core_fail <= ~fail_next; // fail carries no meaning outside done
		if (rst) begin
			cnt_q <= 0;
		end else if (core_start) begin
			cnt_q <= LAT;
		end else if (cnt_q > 1) begin
			cnt_q <= cnt_q - 1;
		end else if (cnt_q == 1) begin
			cnt_q <= 0;
			core_done <= 1'b1;
			core_fail <= fail_next;
		end
	end
endmodule

// ---- verification/tb_flash_rewrite_protect_control.sv ----
module tb_flash_rewrite_protect_control;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        clk_sys = 0, rst = 1;
	logic [4:0]  avs_address = 0;
	logic        avs_read = 0, avs_write = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, q;
	logic        avs_waitrequest, par_mode_pin = 0, ser_mode_pin = 0;
	logic        ser_id_restart = 0, ser_id_valid = 0, ctl_block_unlocked = 0, boot_lo = 0;
	logic [7:0]  ser_id_byte = 0;
	logic [31:0] reset_vector = 32'h0000_1234;
	logic        core_done, core_fail, core_start, fail_next = 0;
	logic [2:0]  core_op;
	logic [4:0]  core_block;
	logic        boot_mode, boot_rom_sel, par_access_en, boot_rewrite_en, ser_cmd_accept;
	logic        cpu_hold, io_freeze, block_a_en, ext_area_en, read_status_mode;
	localparam logic [55:0] SID = 56'h11_2233_4455_6677;
	int err_total = 0, tests_run = 0;
	always #2 clk_sys = ~clk_sys;
	// ----------------------------------------
	// design and flash array model
	// ----------------------------------------
	frpc_top DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.boot_select_low_pin(boot_lo), .boot_select_high_pin(1'b1), .processor_mode_pin(1'b1),
		.par_mode_pin(par_mode_pin), .ser_mode_pin(ser_mode_pin),
		.ser_id_restart(ser_id_restart), .ser_id_valid(ser_id_valid),
		.ser_id_byte(ser_id_byte), .stored_id(SID), .reset_vector(reset_vector),
		.ctl_block_unlocked(ctl_block_unlocked), .core_done(core_done),
		.core_fail(core_fail), .core_start(core_start), .core_op(core_op),
		.core_block(core_block), .boot_mode(boot_mode), .boot_rom_sel(boot_rom_sel),
		.par_access_en(par_access_en), .boot_rewrite_en(boot_rewrite_en),
		.ser_cmd_accept(ser_cmd_accept), .cpu_hold(cpu_hold), .io_freeze(io_freeze),
		.block_a_en(block_a_en), .ext_area_en(ext_area_en),
		.read_status_mode(read_status_mode));
	frpc_core_model core (.clk_sys(clk_sys), .rst(rst), .core_start(core_start),
		.fail_next(fail_next), .core_done(core_done), .core_fail(core_fail));
	// ----------------------------------------
	// bus cycles and comparison
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// request held until waitrequest is sampled low at a rising edge, released at that edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 300);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 300) chk("bus wait", 0, 1);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 8'h00);
	endtask
	// poll ready until the running flash op has finished
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			rd(frpc_pkg::OFS_CTL_FIRST);
			n++;
		end while (q[0] !== 1'b1 && n < 100);
	endtask
	task automatic wait_sync();
		repeat (4) @(posedge clk_sys);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_boot();
		chk("boot_mode", 1, boot_mode);
		chk("boot_rom_sel", 1, boot_rom_sel);
		rd(frpc_pkg::OFS_PROTECT);
		chk("protect", 32'h0000_00FF, q);
		rd(frpc_pkg::OFS_CTL_FIRST);
		chk("ctl_first", 32'h0000_0001, q);
		rd(5'h1C);
		chk("unmapped", 0, q);
		wr(frpc_pkg::OFS_CTL_FIRST, 8'h22);
		wait_sync();
		chk("user area", 0, boot_rom_sel);
	endtask
	task automatic t_enable();
		wr(frpc_pkg::OFS_CTL_FIRST, 8'h22);
		rd(frpc_pkg::OFS_CTL_FIRST);
		chk("lone one", 32'h0000_0021, q);
		chk("block a off", 0, block_a_en);
		wr(frpc_pkg::OFS_CTL_FIRST, 8'h20);
		wr(frpc_pkg::OFS_CTL_FIRST, 8'h22);
		rd(frpc_pkg::OFS_CTL_FIRST);
		chk("enable", 32'h0000_0023, q);
		chk("block a", 1, block_a_en);
		chk("ext area", 1, ext_area_en);
		rd(frpc_pkg::OFS_CTL_SECOND);
		chk("mode zero", 0, q);
	endtask
	task automatic t_ew0_program();
		fail_next <= 1'b1;
		wr(frpc_pkg::OFS_COMMAND, 8'h1A);
		@(negedge clk_sys);
		chk("core_start", 1, core_start);
		chk("core_op", 2, core_op);
		chk("core_block", 3, core_block);
		chk("no hold", 0, cpu_hold);
		rd(frpc_pkg::OFS_CTL_FIRST);
		chk("busy", 0, q[0]);
		wait_ready();
		chk("prog err", 32'h0000_0063, q);
		rd(frpc_pkg::OFS_STATUS);
		chk("status", 32'h0000_0090, q);
		chk("status mode", 1, read_status_mode);
	endtask
	task automatic t_protect();
		par_mode_pin <= 1'b1;
		wr(frpc_pkg::OFS_CTL_FIRST, 8'h20);
		wait_sync();
		chk("boot rw open", 1, boot_rewrite_en);
		wr(frpc_pkg::OFS_CTL_FIRST, 8'h22);
		wr(frpc_pkg::OFS_PROTECT, 8'h3F);
		wait_sync();
		chk("par blocked", 0, par_access_en);
		chk("boot rw blocked", 0, boot_rewrite_en);
		fail_next <= 1'b0;
		wr(frpc_pkg::OFS_COMMAND, 8'h03);
		wait_ready();
		rd(frpc_pkg::OFS_PROTECT);
		chk("protect erased", 32'h0000_00FF, q);
		wait_sync();
		chk("par open", 1, par_access_en);
		chk("boot rw cpu", 0, boot_rewrite_en);
		par_mode_pin <= 1'b0;
	endtask
	task automatic t_ew1();
		logic [7:0] cmd [4] = '{8'h52, 8'h04, 8'h01, 8'h04};
		logic       unl [4] = '{0, 1, 0, 0};
		logic       ld [4] = '{0, 0, 0, 1};
		wr(frpc_pkg::OFS_CTL_SECOND, 8'h00);
		wr(frpc_pkg::OFS_CTL_SECOND, 8'h02);
		wr(frpc_pkg::OFS_EXEC_BLOCK, 8'h0A);
		rd(frpc_pkg::OFS_CTL_SECOND);
		chk("mode one", 32'h0000_0002, q);
		rd(frpc_pkg::OFS_STATUS);
		chk("status hidden", 0, q);
		for (int i = 0; i < 4; i++) begin
			ctl_block_unlocked <= unl[i];
			wr(frpc_pkg::OFS_CTL_FIRST, {5'h04, ld[i], 2'h2});
			wr(frpc_pkg::OFS_COMMAND, cmd[i]);
			rd(frpc_pkg::OFS_CTL_SECOND);
			chk("reject", 1, q[7]);
			rd(frpc_pkg::OFS_CTL_FIRST);
			chk("not started", 1, q[0]);
		end
		wr(frpc_pkg::OFS_CTL_FIRST, 8'h22);
		fail_next <= 1'b1;
		wr(frpc_pkg::OFS_COMMAND, 8'h13);
		repeat (3) @(negedge clk_sys);
		chk("cpu hold", 1, cpu_hold);
		chk("io freeze", 1, io_freeze);
		wait_ready();
		chk("erase err", 1, q[7]);
		chk("array mode", 0, read_status_mode);
	endtask
	task automatic send_id(input logic [55:0] id);
		@(posedge clk_sys);
		ser_id_restart <= 1'b1;
		@(posedge clk_sys);
		ser_id_restart <= 1'b0;
		for (int i = 0; i < frpc_pkg::ID_BYTES; i++) begin
			@(posedge clk_sys);
			ser_id_valid <= 1'b1;
			ser_id_byte <= id[8*i +: 8];
			@(posedge clk_sys);
			ser_id_valid <= 1'b0;
		end
		wait_sync();
	endtask
	task automatic t_serial();
		ser_mode_pin <= 1'b1;
		wait_sync();
		send_id(SID);
		chk("id match", 1, ser_cmd_accept);
		send_id(SID ^ 56'h80_0000_0000_0000);
		chk("id mismatch", 0, ser_cmd_accept);
		reset_vector <= frpc_pkg::VECTOR_ERASED;
		wait_sync();
		chk("vector erased", 1, ser_cmd_accept);
	endtask
	// second reset with the low boot strap high: normal start from user area
	task automatic t_user_boot();
		boot_lo <= 1'b1;
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("user boot", 0, boot_mode);
		chk("no boot rom", 0, boot_rom_sel);
		rd(frpc_pkg::OFS_CTL_FIRST);
		chk("ctl after reset", 32'h0000_0001, q);
	endtask
	// ----------------------------------------
	// verdict, watchdog and main sequence
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		t_reset_boot();
		t_enable();
		t_ew0_program();
		t_protect();
		t_ew1();
		t_serial();
		t_user_boot();
		tally_and_finish();
	end
endmodule
